// File: eapr_pkg.sv
package eapr_pkg;
    // =========================================================
    // timing
    // =========================================================
    localparam int CLK_PERIOD_NS   = 50;
    // least low width accepted as a real pin reset
    localparam int FILT_MIN_NS     = 300;
    localparam int FILT_CYCLES     = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W          = 4;
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);
    localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;
    localparam logic [FILT_W-1:0] FILT_ONE  = 4'h1;
    // length of the power-on pulse
    localparam int POR_PULSE_NS    = 200;
    localparam int POR_CYCLES      = POR_PULSE_NS / CLK_PERIOD_NS;
    localparam int POR_W           = 4;
    localparam logic [POR_W-1:0]  POR_LAST  = POR_W'(POR_CYCLES - 1);
    localparam logic [POR_W-1:0]  POR_ZERO  = 4'h0;
    localparam logic [POR_W-1:0]  POR_ONE   = 4'h1;
    // =========================================================
    // flag values
    // =========================================================
    localparam logic POR_FLAG_CLEAR = 1'h0;
    localparam logic POR_FLAG_SET   = 1'h1;
    // power-on sequencer states
    typedef enum logic [1:0] {EAPR_PWR_ACTIVE, EAPR_PWR_DONE} eapr_pwr_e;
endpackage : eapr_pkg

// File: eapr_glitch_filter.sv
`timescale 1ns/1ps
// =========================================================
// pin low-pulse filter
// =========================================================
module eapr_glitch_filter
    import eapr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinLow,
    output logic      lowStable
);
    logic [FILT_W-1:0] lowCount;

    // count consecutive low cycles, drop back on any high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowCount <= FILT_ZERO;
        end else if (!pinLow) begin
            lowCount <= FILT_ZERO;
        end else if (lowCount != FILT_LAST) begin
            lowCount <= lowCount + FILT_ONE;
        end
    end

    // assert only once the low held the full window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowStable <= 1'h0;
        end else begin
            lowStable <= pinLow && (lowCount == FILT_LAST);
        end
    end

    AST_SHORT_LOW_REJECTED: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lowStable) |-> $past(pinLow, 1) && $past(pinLow, 2) && $past(pinLow, 3)
            && $past(pinLow, 4) && $past(pinLow, 5) && $past(pinLow, 6))
        else $error("filter passed a short low pulse");
endmodule : eapr_glitch_filter

// File: eapr_reset_ctrl.sv
`timescale 1ns/1ps
// Contract
// - While the pin reset function is enabled and the pin is held low, the device stays in reset.
// - Short low pulses on the reset pin are filtered out and cause no reset.
// - The device never drives the reset pin, not even for internal or watchdog resets.
// - With the pin reset disabled, the pin is ignored for reset and read as a digital input.
// - A power-on pulse is generated whenever the supply rises past its threshold.
// - Every power-on event clears the power-on flag to 0.
// - The power-on flag keeps its value across every other kind of reset.
// - Only a software write sets the power-on flag back to 1.
// - The pin is a general input only when the pin reset enable is 0.
module eapr_reset_ctrl
    import eapr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supplyGood,
    input  wire logic externalResetPin,
    output logic      externalResetPinOut,
    output logic      externalResetPinOe_n,
    input  wire logic resetPinEnableCfg,
    input  wire logic otherResetReq,
    input  wire logic watchdogResetReq,
    input  wire logic porFlagWrite,
    input  wire logic porFlagWdata,
    output logic      porFlag,
    output logic      generalInput,
    output logic      pinResetActive,
    output logic      powerOnPulse,
    output logic      resetRequest
);
    // =========================================================
    // pin: input only
    // =========================================================
    // output tied low and never enabled, even for internal resets
    assign externalResetPinOut  = 1'h0;
    assign externalResetPinOe_n = 1'h1;

    // gated pin level and its filtered copy
    logic pinLowGated;
    logic pinFiltered;

    // pin reset path only when enabled
    assign pinLowGated = resetPinEnableCfg && !externalResetPin;

    // lows shorter than the filter window never get through
    eapr_glitch_filter u_filter (
        .clk       (clk),
        .rst_n     (rst_n),
        .pinLow    (pinLowGated),
        .lowStable (pinFiltered)
    );

    // held in reset while filtered low lasts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinResetActive <= 1'h0;
        end else begin
            pinResetActive <= pinFiltered && pinLowGated;
        end
    end

    // digital input view of the pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            generalInput <= 1'h0;
        end else if (!resetPinEnableCfg) begin
            generalInput <= externalResetPin;
        end else begin
            generalInput <= 1'h0;
        end
    end

    // =========================================================
    // power-on pulse
    // =========================================================
    // pulse state, its cycle count and the supply edge
    eapr_pwr_e         pwrState;
    logic [POR_W-1:0]  porCount;
    logic              supplyPrev;
    logic              supplyRise;

    // supply rise seen against the last sample
    assign supplyRise = supplyGood && !supplyPrev;

    // supply edge detect; supply starts low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            supplyPrev <= 1'h0;
        end else begin
            supplyPrev <= supplyGood;
        end
    end

    // sequencer: pulse on each rise, held active while supply is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwrState <= EAPR_PWR_DONE;
            porCount <= POR_ZERO;
        end else if (!supplyGood || supplyRise) begin
            pwrState <= EAPR_PWR_ACTIVE;
            porCount <= POR_ZERO;
        end else begin
            case (pwrState)
                EAPR_PWR_ACTIVE: begin
                    if (porCount == POR_LAST) begin
                        pwrState <= EAPR_PWR_DONE;
                    end else begin
                        porCount <= porCount + POR_ONE;
                    end
                end
                EAPR_PWR_DONE: begin
                    porCount <= POR_ZERO;
                end
                default: begin
                    pwrState <= EAPR_PWR_DONE;
                end
            endcase
        end
    end

    // pulse straight from the state, held while supply is low
    assign powerOnPulse = (pwrState == EAPR_PWR_ACTIVE);

    // =========================================================
    // power-on flag
    // =========================================================
    // power-on clear wins over a software set
    // a write of 0 does nothing; no hardware path sets the flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            porFlag <= POR_FLAG_CLEAR;
        end else if (powerOnPulse) begin
            porFlag <= POR_FLAG_CLEAR;
        end else if (porFlagWrite && porFlagWdata) begin
            porFlag <= POR_FLAG_SET;
        end
    end

    // =========================================================
    // combined reset request
    // =========================================================
    // any one source is enough; the pin is never driven back
    assign resetRequest = pinResetActive || powerOnPulse
                        || otherResetReq || watchdogResetReq;

    // =========================================================
    // checks
    // =========================================================
    // pin is an input only
    AST_PIN_NEVER_DRIVEN: assert property (@(posedge clk) disable iff (!rst_n)
        externalResetPinOe_n)
        else $error("reset pin driven");
    AST_PIN_OUT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        !externalResetPinOut)
        else $error("reset pin output not low");

    // pin reset path
    AST_PIN_HELD_RESETS: assert property (@(posedge clk) disable iff (!rst_n)
        (resetPinEnableCfg && !externalResetPin) [*7] |=> resetRequest)
        else $error("held low pin gave no reset");
    AST_PIN_HELD_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pinResetActive) |-> !$past(pinLowGated))
        else $error("pin reset dropped while pin held low");
    AST_PIN_NEEDS_FILTER: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pinResetActive) |-> $past(pinLowGated, 1) && $past(pinLowGated, 2)
            && $past(pinLowGated, 3) && $past(pinLowGated, 4) && $past(pinLowGated, 5)
            && $past(pinLowGated, 6) && $past(pinLowGated, 7))
        else $error("pin reset without a full filtered low");
    AST_PIN_RELEASE_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
        !(resetPinEnableCfg && !externalResetPin) |=> !pinResetActive)
        else $error("pin reset outlived the low");
    AST_DISABLED_PIN_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
        !resetPinEnableCfg [*3] |-> !pinResetActive)
        else $error("disabled pin caused reset");
    AST_GENERAL_INPUT_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        $past(resetPinEnableCfg) |-> !generalInput)
        else $error("general input live while pin reset on");
    AST_GENERAL_INPUT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && !$past(resetPinEnableCfg) |-> generalInput == $past(externalResetPin))
        else $error("general input not following pin");

    // power-on pulse
    AST_POR_PULSE_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(supplyGood) |=> powerOnPulse [*4])
        else $error("power-on pulse too short");
    AST_POR_PULSE_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(supplyGood) ##1 supplyGood [*4] |=> !powerOnPulse)
        else $error("power-on pulse too long");
    AST_SUPPLY_LOW_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        !supplyGood |=> powerOnPulse)
        else $error("no pulse while supply low");

    // power-on flag
    AST_POR_CLEARS_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        powerOnPulse |=> !porFlag)
        else $error("power-on did not clear flag");
    AST_FLAG_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
        !powerOnPulse && !(porFlagWrite && porFlagWdata) |=> porFlag == $past(porFlag))
        else $error("flag changed without cause");
    AST_FLAG_SW_SET: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(porFlag) |-> $past(porFlagWrite) && $past(porFlagWdata))
        else $error("flag set by hardware");
    AST_FLAG_SET_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        porFlagWrite && porFlagWdata && !powerOnPulse |=> porFlag)
        else $error("software set of flag lost");

    // combined request
    AST_REQ_OR: assert property (@(posedge clk) disable iff (!rst_n)
        (pinResetActive || otherResetReq || watchdogResetReq || powerOnPulse)
            |-> resetRequest)
        else $error("reset source not in request");
    AST_REQ_ONLY_SOURCES: assert property (@(posedge clk) disable iff (!rst_n)
        !(pinResetActive || otherResetReq || watchdogResetReq || powerOnPulse)
            |-> !resetRequest)
        else $error("reset request without a source");

    // main scenarios reached
    COV_PIN_RESET: cover property (@(posedge clk) disable iff (!rst_n) $rose(pinResetActive));
    COV_POR: cover property (@(posedge clk) disable iff (!rst_n) $fell(powerOnPulse));
    COV_FLAG_SET: cover property (@(posedge clk) disable iff (!rst_n) $rose(porFlag));
    COV_GPIO: cover property (@(posedge clk) disable iff (!rst_n) $rose(generalInput));
    COV_SET_CLASH: cover property (@(posedge clk) disable iff (!rst_n)
        porFlagWrite && porFlagWdata && powerOnPulse);
endmodule : eapr_reset_ctrl

// File: eapr_board_model.sv
`timescale 1ns/1ps
// =========================================================
// board reset switch with pull-up resistor on the pin
// =========================================================
module eapr_board_model (
    input  wire logic pressLow,
    input  wire logic pinOut,
    input  wire logic pinOe_n,
    output logic      pinLevel
);
    // device drive wins, else switch pulls low, else pull-up holds high
    assign pinLevel = !pinOe_n ? pinOut : !pressLow;
endmodule : eapr_board_model

// File: external_and_power_on_reset_tb.sv
`timescale 1ns/1ps
// =========================================================
// testbench
// =========================================================
module external_and_power_on_reset_tb import eapr_pkg::*;;
    logic clk, rst_n, supplyGood, pinLevel, pinOut, pinOe_n, cfg, otherReq, wdReq;
    logic fw, fwd, porFlag, genIn, pinAct, porPulse, resetReq, pressLow;
    int   errors, n_tests;
    // device under test and the board around it
    eapr_reset_ctrl i_dut (.clk(clk), .rst_n(rst_n), .supplyGood(supplyGood),
        .externalResetPin(pinLevel), .externalResetPinOut(pinOut),
        .externalResetPinOe_n(pinOe_n), .resetPinEnableCfg(cfg), .otherResetReq(otherReq),
        .watchdogResetReq(wdReq), .porFlagWrite(fw), .porFlagWdata(fwd), .porFlag(porFlag),
        .generalInput(genIn), .pinResetActive(pinAct), .powerOnPulse(porPulse),
        .resetRequest(resetReq));
    eapr_board_model i_board (.pressLow(pressLow), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .pinLevel(pinLevel));
    // =========================================================
    // helpers
    // =========================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic swWrite(input logic v);
        fw = 1'h1;
        fwd = v;
        cyc(1);
        fw = 1'h0;
    endtask : swWrite
    // =========================================================
    // scenarios
    // =========================================================
    task automatic t_power_on();
        int w, h;
        w = 0;
        h = 0;
        while (porPulse !== 1'h1 && w < 10) begin cyc(1); w++; end
        chk(resetReq, 1'h1, "no reset request in power-on pulse");
        while (porPulse === 1'h1 && h < 10) begin cyc(1); h++; end
        chk(h == POR_CYCLES, 1'h1, "power-on pulse length");
        chk(porFlag, POR_FLAG_CLEAR, "flag not cleared by power-on");
    endtask : t_power_on
    task automatic t_flag();
        swWrite(1'h0);
        cyc(1);
        chk(porFlag, POR_FLAG_CLEAR, "zero write set flag");
        swWrite(1'h1);
        cyc(1);
        chk(porFlag, POR_FLAG_SET, "software set lost");
    endtask : t_flag
    task automatic t_glitch();
        logic seen;
        seen = 1'h0;
        for (int i = 0; i < 9; i++) begin
            pressLow = (i < 5);
            cyc(1);
            if (pinAct !== 1'h0 || resetReq !== 1'h0) seen = 1'h1;
        end
        chk(seen, 1'h0, "short low pulse caused reset");
        chk(genIn, 1'h0, "general input live while pin is reset");
    endtask : t_glitch
    task automatic t_pin_reset();
        pressLow = 1'h1;
        cyc(8);
        chk(pinAct, 1'h1, "held low pin gave no reset");
        chk(resetReq, 1'h1, "pin reset missing from request");
        chk(porFlag, POR_FLAG_SET, "flag changed by pin reset");
        pressLow = 1'h0;
        cyc(2);
        chk(pinAct, 1'h0, "pin reset stuck after release");
    endtask : t_pin_reset
    task automatic t_pin_disabled();
        cfg = 1'h0;
        cyc(1);
        pressLow = 1'h1;
        cyc(10);
        chk(pinAct, 1'h0, "disabled pin caused reset");
        chk(genIn, 1'h0, "general input misses low");
        pressLow = 1'h0;
        cyc(2);
        chk(genIn, 1'h1, "general input misses high");
        cfg = 1'h1;
    endtask : t_pin_disabled
    task automatic t_internal();
        wdReq = 1'h1;
        cyc(1);
        chk(resetReq, 1'h1, "watchdog request lost");
        chk(pinOe_n, 1'h1, "pin driven on internal reset");
        chk(pinLevel, 1'h1, "pin pulled low on internal reset");
        chk(pinOut, 1'h0, "pin output not held low");
        wdReq = 1'h0;
        otherReq = 1'h1;
        cyc(1);
        chk(resetReq, 1'h1, "other request lost");
        otherReq = 1'h0;
        cyc(1);
        chk(resetReq, 1'h0, "request without source");
        chk(porFlag, POR_FLAG_SET, "flag changed by internal reset");
    endtask : t_internal
    task automatic t_power_cycle();
        supplyGood = 1'h0;
        cyc(3);
        chk(porPulse, 1'h1, "no pulse while supply low");
        chk(porFlag, POR_FLAG_CLEAR, "supply loss kept flag");
        supplyGood = 1'h1;
        cyc(2);
        swWrite(1'h1);
        chk(porFlag, POR_FLAG_CLEAR, "set won over power-on clear");
        cyc(6);
        chk(porFlag, POR_FLAG_CLEAR, "flag set without software");
        chk(porPulse, 1'h0, "power-on pulse did not end");
        swWrite(1'h1);
        cyc(1);
        chk(porFlag, POR_FLAG_SET, "re-arm write lost");
    endtask : t_power_cycle
    // =========================================================
    // clock, main sequence, watchdog
    // =========================================================
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, otherReq, wdReq, fw, fwd, pressLow} = 6'h0;
        {supplyGood, cfg} = 2'h3;
        errors = 0;
        n_tests = 0;
        cyc(5);
        rst_n = 1'h1;
        t_power_on();
        t_flag();
        t_glitch();
        t_pin_reset();
        t_pin_disabled();
        t_internal();
        t_power_cycle();
        conclude();
    end
    initial begin
        #200000;
        errors++;
        $display("MISMATCH %0t run hung", $time);
        conclude();
    end
endmodule : external_and_power_on_reset_tb
